// ---- logic/apg_bclk_gen.sv ----
// bit clock generator: accumulator in master mode, edge finder in slave mode
`timescale 1ns/1ps
module apg_bclk_gen
  import apg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic master,
  input wire logic run,
  input wire logic pin_sync,
  input wire logic [APG_ACC_W-1:0] inc,
  apg_clk_if.src bc
);
  logic [APG_ACC_W-1:0] acc_reg;
  logic [APG_ACC_W:0] sum;
  logic level_next;

  assign sum = {1'b0, acc_reg} + {1'b0, inc};

  always_comb
  begin
    level_next = bc.level;
    if (!master)
    begin
      level_next = pin_sync;
    end
    else if (run && sum[APG_ACC_W])
    begin
      level_next = ~bc.level;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn || !master || !run)
    begin
      acc_reg <= '0;
    end
    else
    begin
      acc_reg <= sum[APG_ACC_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      bc.level <= 1'b0;
      bc.rise <= 1'b0;
      bc.fall <= 1'b0;
    end
    else
    begin
      bc.level <= level_next;
      bc.rise <= level_next & ~bc.level;
      bc.fall <= ~level_next & bc.level;
    end
  end
endmodule

// ---- logic/apg_clk_if.sv ----
// bit clock level and edge pulses shared between generator and dividers
`timescale 1ns/1ps
interface apg_clk_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport snk (input level, input rise, input fall);
endinterface

// ---- logic/apg_clock_gen.sv ----
// top: bit and frame clock generation with configuration check for three audio ports
`timescale 1ns/1ps
module apg_clock_gen
  import apg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [APG_PORTS-1:0] bclk_in,
  output logic [APG_PORTS-1:0] bclk_out,
  output logic [APG_PORTS-1:0] bclk_oe_n,
  input wire logic [APG_PORTS-1:0] rx_frame_in,
  output logic [APG_PORTS-1:0] rx_frame_out,
  output logic [APG_PORTS-1:0] rx_frame_oe_n,
  input wire logic [APG_PORTS-1:0] tx_frame_in,
  output logic [APG_PORTS-1:0] tx_frame_out,
  output logic [APG_PORTS-1:0] tx_frame_oe_n,
  output logic [APG_PORTS-1:0] tx_path_frame,
  output logic [APG_PORTS-1:0] async_domain,
  output logic [APG_PORTS-1:0] config_error
);
  logic [APG_RATE_W-1:0] rate_code_reg [APG_PORTS];
  logic [APG_BCPF_W-1:0] rx_div_reg [APG_PORTS];
  logic [APG_BCPF_W-1:0] tx_div_reg [APG_PORTS];
  logic [APG_CTRL_W-1:0] ctrl_reg [APG_PORTS];
  logic [15:0] rx_slot_reg [APG_PORTS];
  logic [15:0] tx_slot_reg [APG_PORTS];
  logic [APG_RATE_W-1:0] sys_rate_reg;
  logic [APG_RATE_W-1:0] async_rate_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [APG_PORTS-1:0] bclk_s1_reg;
  logic [APG_PORTS-1:0] bclk_s2_reg;
  logic [APG_PORTS-1:0] rxf_s1_reg;
  logic [APG_PORTS-1:0] rxf_s2_reg;
  logic [APG_PORTS-1:0] txf_s1_reg;
  logic [APG_PORTS-1:0] txf_s2_reg;
  logic [APG_PORTS-1:0] bclk_reg;
  logic [APG_PORTS-1:0] bclk_oe_n_reg;
  logic [APG_PORTS-1:0] rxf_reg;
  logic [APG_PORTS-1:0] rxf_oe_n_reg;
  logic [APG_PORTS-1:0] txf_reg;
  logic [APG_PORTS-1:0] txf_oe_n_reg;
  logic [APG_PORTS-1:0] tx_path_reg;
  logic [APG_PORTS-1:0] dom_reg;
  logic [APG_PORTS-1:0] err_reg;
  logic [APG_PORTS-1:0] bad_reg;
  wire [APG_PORTS-1:0] p_bclk;
  wire [APG_PORTS-1:0] p_rx_frame;
  wire [APG_PORTS-1:0] p_tx_frame;
  wire [APG_PORTS-1:0] p_dom;
  wire [APG_PORTS-1:0] p_bad;
  wire [APG_PORTS-1:0] p_conflict;

  assign reg_rdata = rdata_reg;
  assign bclk_out = bclk_reg;
  assign bclk_oe_n = bclk_oe_n_reg;
  assign rx_frame_out = rxf_reg;
  assign rx_frame_oe_n = rxf_oe_n_reg;
  assign tx_frame_out = txf_reg;
  assign tx_frame_oe_n = txf_oe_n_reg;
  assign tx_path_frame = tx_path_reg;
  assign async_domain = dom_reg;
  assign config_error = err_reg;

  // pin inputs pass two flip-flops before use
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      bclk_s1_reg <= '0;
      bclk_s2_reg <= '0;
      rxf_s1_reg <= '0;
      rxf_s2_reg <= '0;
      txf_s1_reg <= '0;
      txf_s2_reg <= '0;
    end
    else
    begin
      bclk_s1_reg <= bclk_in;
      bclk_s2_reg <= bclk_s1_reg;
      rxf_s1_reg <= rx_frame_in;
      rxf_s2_reg <= rxf_s1_reg;
      txf_s1_reg <= tx_frame_in;
      txf_s2_reg <= txf_s1_reg;
    end
  end

  // bit clock rate codes
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int p = 0; p < APG_PORTS; p++)
      begin
        rate_code_reg[p] <= APG_RATE_RST;
      end
    end
    else if (reg_wr)
    begin
      for (int p = 0; p < APG_PORTS; p++)
      begin
        if (reg_addr == APG_RATE_OFS[p])
        begin
          rate_code_reg[p] <= reg_wdata[APG_RATE_W-1:0];
        end
      end
    end
  end

  // cycles-per-frame dividers
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int p = 0; p < APG_PORTS; p++)
      begin
        rx_div_reg[p] <= APG_BCPF_RST;
        tx_div_reg[p] <= APG_BCPF_RST;
      end
    end
    else if (reg_wr)
    begin
      for (int p = 0; p < APG_PORTS; p++)
      begin
        if (reg_addr == APG_RXDIV_OFS[p])
        begin
          rx_div_reg[p] <= reg_wdata[APG_BCPF_W-1:0];
        end
        else if (reg_addr == APG_TXDIV_OFS[p])
        begin
          tx_div_reg[p] <= reg_wdata[APG_BCPF_W-1:0];
        end
      end
    end
  end

  // port control and channel slot assignment
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int p = 0; p < APG_PORTS; p++)
      begin
        ctrl_reg[p] <= '0;
        rx_slot_reg[p] <= 16'h0100;
        tx_slot_reg[p] <= 16'h0100;
      end
    end
    else if (reg_wr)
    begin
      for (int p = 0; p < APG_PORTS; p++)
      begin
        if (reg_addr == APG_CTRL_OFS[p])
        begin
          ctrl_reg[p] <= reg_wdata[APG_CTRL_W-1:0];
        end
        else if (reg_addr == APG_RXSL_OFS[p])
        begin
          rx_slot_reg[p] <= reg_wdata & 16'h3f3f;
        end
        else if (reg_addr == APG_TXSL_OFS[p])
        begin
          tx_slot_reg[p] <= reg_wdata & 16'h3f3f;
        end
      end
    end
  end

  // sample rate settings of both clock domains
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sys_rate_reg <= '0;
      async_rate_reg <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == APG_SYSRATE_OFS)
      begin
        sys_rate_reg <= reg_wdata[APG_RATE_W-1:0];
      end
      else if (reg_addr == APG_ASYRATE_OFS)
      begin
        async_rate_reg <= reg_wdata[APG_RATE_W-1:0];
      end
    end
  end

  // register read decode, unmapped addresses read zero
  always_comb
  begin
    rdata_next = '0;
    if (reg_addr == APG_SYSRATE_OFS)
    begin
      rdata_next = {11'h000, sys_rate_reg};
    end
    else if (reg_addr == APG_ASYRATE_OFS)
    begin
      rdata_next = {11'h000, async_rate_reg};
    end
    else if (reg_addr == APG_STAT_OFS)
    begin
      rdata_next = {7'h00, bad_reg, dom_reg, err_reg};
    end
    for (int p = 0; p < APG_PORTS; p++)
    begin
      if (reg_addr == APG_RATE_OFS[p])
      begin
        rdata_next = {11'h000, rate_code_reg[p]};
      end
      else if (reg_addr == APG_CTRL_OFS[p])
      begin
        rdata_next = {4'h0, ctrl_reg[p]};
      end
      else if (reg_addr == APG_RXSL_OFS[p])
      begin
        rdata_next = rx_slot_reg[p];
      end
      else if (reg_addr == APG_TXSL_OFS[p])
      begin
        rdata_next = tx_slot_reg[p];
      end
      else if (reg_addr == APG_TXDIV_OFS[p])
      begin
        rdata_next = {3'h0, tx_div_reg[p]};
      end
      else if (reg_addr == APG_RXDIV_OFS[p])
      begin
        rdata_next = {3'h0, rx_div_reg[p]};
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdata_reg <= '0;
    end
    else if (reg_rd)
    begin
      rdata_reg <= rdata_next;
    end
  end

  for (genvar p = 0; p < APG_PORTS; p++)
  begin : g_port
    logic fam44;
    logic [APG_ACC_W-1:0] inc;
    logic [3:0] idx;
    logic [APG_SLOT_W-1:0] rx1;
    logic [APG_SLOT_W-1:0] rx2;
    logic [APG_SLOT_W-1:0] tx1;
    logic [APG_SLOT_W-1:0] tx2;
    apg_clk_if bc ();

    assign p_dom[p] = ctrl_reg[p][APG_CTRL_SEL_MSB:APG_CTRL_SEL_LSB] >= APG_ASYNC_SEL;
    // family follows the setting of whichever domain owns the port
    assign fam44 = p_dom[p] ? (async_rate_reg[4:3] == APG_FAM44_PAT) :
      (sys_rate_reg[4:3] == APG_FAM44_PAT);
    assign p_bad[p] = (rate_code_reg[p] < APG_CODE_MIN) ||
      (rate_code_reg[p] > APG_CODE_MAX);
    assign idx = 4'(rate_code_reg[p] - APG_CODE_MIN);
    assign inc = fam44 ? APG_INC44[idx] : APG_INC48[idx];
    assign rx1 = rx_slot_reg[p][APG_SLOT_W-1:0];
    assign rx2 = rx_slot_reg[p][APG_SLOT2_LSB+APG_SLOT_W-1:APG_SLOT2_LSB];
    assign tx1 = tx_slot_reg[p][APG_SLOT_W-1:0];
    assign tx2 = tx_slot_reg[p][APG_SLOT2_LSB+APG_SLOT_W-1:APG_SLOT2_LSB];
    assign p_conflict[p] = (ctrl_reg[p][APG_CTRL_RX1] && ctrl_reg[p][APG_CTRL_RX2] &&
      rx1 == rx2) || (ctrl_reg[p][APG_CTRL_TX1] && ctrl_reg[p][APG_CTRL_TX2] && tx1 == tx2);
    assign p_bclk[p] = bc.level;

    // reserved codes stop the bit clock rather than run at a bogus rate
    apg_bclk_gen u_bclk (
      .clk(clk),
      .resetn(resetn),
      .master(ctrl_reg[p][APG_CTRL_MSTR]),
      .run(!p_bad[p]),
      .pin_sync(bclk_s2_reg[p]),
      .inc(inc),
      .bc(bc.src)
    );

    apg_frame_div u_rx_div (
      .clk(clk),
      .resetn(resetn),
      .bc(bc.snk),
      .cycles(rx_div_reg[p]),
      .frame(p_rx_frame[p])
    );

    apg_frame_div u_tx_div (
      .clk(clk),
      .resetn(resetn),
      .bc(bc.snk),
      .cycles(tx_div_reg[p]),
      .frame(p_tx_frame[p])
    );
  end

  // pin drivers, frame selection and status flags
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      bclk_reg <= '0;
      bclk_oe_n_reg <= '1;
      rxf_reg <= '0;
      rxf_oe_n_reg <= '1;
      txf_reg <= '0;
      txf_oe_n_reg <= '1;
      tx_path_reg <= '0;
      dom_reg <= '0;
      err_reg <= '0;
      bad_reg <= '0;
    end
    else
    begin
      for (int p = 0; p < APG_PORTS; p++)
      begin
        bclk_reg[p] <= ctrl_reg[p][APG_CTRL_MSTR] & p_bclk[p];
        bclk_oe_n_reg[p] <= ~ctrl_reg[p][APG_CTRL_MSTR];
        rxf_reg[p] <= ctrl_reg[p][APG_CTRL_MSTR] & p_rx_frame[p];
        rxf_oe_n_reg[p] <= ~ctrl_reg[p][APG_CTRL_MSTR];
        txf_reg[p] <= ctrl_reg[p][APG_CTRL_MSTR] & ctrl_reg[p][APG_CTRL_TXGPIO] &
          p_tx_frame[p];
        txf_oe_n_reg[p] <= ~(ctrl_reg[p][APG_CTRL_MSTR] & ctrl_reg[p][APG_CTRL_TXGPIO]);
        if (!ctrl_reg[p][APG_CTRL_TXSRC])
        begin
          tx_path_reg[p] <= ctrl_reg[p][APG_CTRL_MSTR] ? p_rx_frame[p] : rxf_s2_reg[p];
        end
        else if (ctrl_reg[p][APG_CTRL_MSTR] && ctrl_reg[p][APG_CTRL_TXGPIO])
        begin
          tx_path_reg[p] <= p_tx_frame[p];
        end
        else
        begin
          tx_path_reg[p] <= txf_s2_reg[p];
        end
        dom_reg[p] <= p_dom[p];
        err_reg[p] <= p_conflict[p];
        bad_reg[p] <= p_bad[p];
      end
    end
  end
endmodule

// ---- logic/apg_frame_div.sv ----
// frame clock divider counting bit clock falling edges
`timescale 1ns/1ps
module apg_frame_div
  import apg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  apg_clk_if.snk bc,
  input wire logic [APG_BCPF_W-1:0] cycles,
  output logic frame
);
  logic [APG_BCPF_W-1:0] cnt_reg;
  logic [APG_BCPF_W-1:0] cnt_next;

  assign cnt_next = (cnt_reg >= APG_BCPF_W'(cycles - 13'h1)) ? '0 :
    APG_BCPF_W'(cnt_reg + 13'h1);

  // high for the first half of each frame, no gap between frames
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cnt_reg <= '0;
      frame <= 1'b0;
    end
    else if (bc.fall)
    begin
      cnt_reg <= cnt_next;
      frame <= cnt_next < (cycles >> 1);
    end
  end
endmodule

// ---- logic/apg_pkg.sv ----
// constants, register map and rate tables for the audio port clock generator
package apg_pkg;
  localparam int APG_PORTS = 3;
  localparam int APG_RATE_W = 5;
  localparam int APG_BCPF_W = 13;
  localparam int APG_ACC_W = 24;
  localparam int APG_CODES = 16;
  localparam longint unsigned APG_CLK_HZ = 250000000;
  // register byte addresses per port
  localparam logic [15:0] APG_RATE_OFS [APG_PORTS] = '{16'h0500, 16'h0540, 16'h0580};
  localparam logic [15:0] APG_CTRL_OFS [APG_PORTS] = '{16'h0501, 16'h0541, 16'h0581};
  localparam logic [15:0] APG_RXSL_OFS [APG_PORTS] = '{16'h0502, 16'h0542, 16'h0582};
  localparam logic [15:0] APG_TXSL_OFS [APG_PORTS] = '{16'h0503, 16'h0543, 16'h0583};
  localparam logic [15:0] APG_TXDIV_OFS [APG_PORTS] = '{16'h0505, 16'h0545, 16'h0585};
  localparam logic [15:0] APG_RXDIV_OFS [APG_PORTS] = '{16'h0506, 16'h0546, 16'h0586};
  localparam logic [15:0] APG_SYSRATE_OFS = 16'h0600;
  localparam logic [15:0] APG_ASYRATE_OFS = 16'h0601;
  localparam logic [15:0] APG_STAT_OFS = 16'h0602;
  // control register fields
  localparam int APG_CTRL_W = 12;
  localparam int APG_CTRL_MSTR = 0;
  localparam int APG_CTRL_TXSRC = 1;
  localparam int APG_CTRL_TXGPIO = 2;
  localparam int APG_CTRL_SEL_LSB = 4;
  localparam int APG_CTRL_SEL_MSB = 7;
  localparam int APG_CTRL_RX1 = 8;
  localparam int APG_CTRL_RX2 = 9;
  localparam int APG_CTRL_TX1 = 10;
  localparam int APG_CTRL_TX2 = 11;
  localparam int APG_SLOT_W = 6;
  localparam int APG_SLOT2_LSB = 8;
  // reset values and code limits
  localparam logic [APG_RATE_W-1:0] APG_RATE_RST = 5'h0c;
  localparam logic [APG_BCPF_W-1:0] APG_BCPF_RST = 13'h0040;
  localparam logic [APG_RATE_W-1:0] APG_CODE_MIN = 5'h02;
  localparam logic [APG_RATE_W-1:0] APG_CODE_MAX = 5'h11;
  localparam logic [3:0] APG_ASYNC_SEL = 4'h8;
  localparam logic [1:0] APG_FAM44_PAT = 2'h1;
  typedef int unsigned apg_hz_t [APG_CODES];
  typedef logic [APG_ACC_W-1:0] apg_inc_t [APG_CODES];
  // bit clock frequencies for codes 00010 upward
  localparam apg_hz_t APG_F48 = '{64000, 96000, 128000, 192000, 256000, 384000, 512000,
    768000, 1024000, 1536000, 2048000, 3072000, 4096000, 6144000, 8192000, 12288000};
  localparam apg_hz_t APG_F44 = '{58800, 88200, 117600, 176400, 235200, 352800, 470400,
    705600, 940800, 1411200, 1881600, 2822400, 3763200, 5644800, 7526400, 11289600};
  // accumulator step giving two toggles per bit clock period
  function automatic apg_inc_t apg_make_inc(apg_hz_t hz);
    apg_inc_t t;
    longint unsigned v;
    for (int i = 0; i < APG_CODES; i++)
    begin
      v = (longint'(hz[i]) << (APG_ACC_W + 1)) / APG_CLK_HZ;
      t[i] = v[APG_ACC_W-1:0];
    end
    return t;
  endfunction
  localparam apg_inc_t APG_INC48 = apg_make_inc(APG_F48);
  localparam apg_inc_t APG_INC44 = apg_make_inc(APG_F44);
endpackage

// ---- tb/apg_clock_gen_properties.sv ----
// pin level and register read data checks for the audio port clock generator
`timescale 1ns/1ps
module apg_clock_gen_properties
  import apg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [APG_PORTS-1:0] bclk_out,
  input wire logic [APG_PORTS-1:0] bclk_oe_n,
  input wire logic [APG_PORTS-1:0] rx_frame_out,
  input wire logic [APG_PORTS-1:0] rx_frame_oe_n,
  input wire logic [APG_PORTS-1:0] tx_frame_out,
  input wire logic [APG_PORTS-1:0] tx_frame_oe_n,
  input wire logic [APG_PORTS-1:0] async_domain,
  input wire logic [APG_PORTS-1:0] config_error
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_bclk_slave_quiet: assert property ((bclk_out & bclk_oe_n) == '0)
    else $error("bit clock driven while released");
  a_rx_slave_quiet: assert property ((rx_frame_out & rx_frame_oe_n) == '0)
    else $error("rx frame driven while released");
  a_tx_slave_quiet: assert property ((tx_frame_out & tx_frame_oe_n) == '0)
    else $error("tx frame driven while released");
  a_oe_pair_match: assert property (bclk_oe_n == rx_frame_oe_n)
    else $error("bit clock and frame enables differ");
  a_tx_oe_master: assert property ((~tx_frame_oe_n & rx_frame_oe_n) == '0)
    else $error("tx frame driven in slave mode");
  a_bclk_high_width: assert property ($rose(bclk_out[0]) |=> (bclk_out[0] || bclk_oe_n[0])[*8])
    else $error("bit clock high phase too short");
  a_rdata_holds_idle: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_status_error_bits: assert property (reg_rd && reg_addr == APG_STAT_OFS |=>
    reg_rdata[2:0] == $past(config_error))
    else $error("status error bits differ from flags");
  a_status_domain_bits: assert property (reg_rd && reg_addr == APG_STAT_OFS |=>
    reg_rdata[5:3] == $past(async_domain))
    else $error("status domain bits differ from outputs");
endmodule
bind apg_clock_gen apg_clock_gen_properties u_props (.clk, .resetn, .reg_addr, .reg_rd,
  .reg_rdata, .bclk_out, .bclk_oe_n, .rx_frame_out, .rx_frame_oe_n, .tx_frame_out,
  .tx_frame_oe_n, .async_domain, .config_error);

// ---- tb/apg_far_end.sv ----
// far end serial port model: bit clock and frame source for slave tests
`timescale 1ns/1ps
module apg_far_end
#(
  parameter int HALF = 5,
  parameter int NBITS = 8
)
(
  input wire logic clk,
  input wire logic en,
  output logic bclk,
  output logic frame
);
  int cnt_reg = 0;
  int bit_reg = 0;
  initial
  begin
    bclk = 1'b0;
    frame = 1'b0;
  end
  // released lines flip every cycle so no stale level is seen
  always @(posedge clk)
  begin
    cnt_reg <= (en && cnt_reg < HALF - 1) ? cnt_reg + 1 : 0;
    if (!en)
    begin
      bclk <= ~bclk;
      frame <= ~frame;
    end
    else if (cnt_reg == HALF - 1)
    begin
      bclk <= ~bclk;
      if (bclk)
      begin
        bit_reg <= (bit_reg + 1) % NBITS;
        frame <= ((bit_reg + 1) % NBITS) < NBITS / 2;
      end
    end
  end
endmodule

// ---- tb/test_audio_port_bit_frame_clock_gen.sv ----
// self-checking bench for the audio port clock generator
`timescale 1ns/1ps
module test_audio_port_bit_frame_clock_gen
  import apg_pkg::*;
;
  logic clk, resetn, reg_wr, reg_rd, fe_en, fe_bclk, fe_frame;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [2:0] bclk_in, bclk_out, bclk_oe_n, rx_frame_in, rx_frame_out, rx_frame_oe_n;
  logic [2:0] tx_frame_in, tx_frame_out, tx_frame_oe_n, tx_path_frame, async_domain;
  logic [2:0] config_error;
  int failures = 0;
  int n_checks = 0;
  // pin level from whichever side drives it
  assign bclk_in = (bclk_oe_n & {3{fe_bclk}}) | (~bclk_oe_n & bclk_out);
  assign rx_frame_in = (rx_frame_oe_n & {3{fe_frame}}) | (~rx_frame_oe_n & rx_frame_out);
  assign tx_frame_in = (tx_frame_oe_n & {3{fe_frame}}) | (~tx_frame_oe_n & tx_frame_out);
  apg_clock_gen uut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bclk_in(bclk_in), .bclk_out(bclk_out), .bclk_oe_n(bclk_oe_n),
    .rx_frame_in(rx_frame_in), .rx_frame_out(rx_frame_out), .rx_frame_oe_n(rx_frame_oe_n),
    .tx_frame_in(tx_frame_in), .tx_frame_out(tx_frame_out), .tx_frame_oe_n(tx_frame_oe_n),
    .tx_path_frame(tx_path_frame), .async_domain(async_domain),
    .config_error(config_error));
  apg_far_end far (.clk(clk), .en(fe_en), .bclk(fe_bclk), .frame(fe_frame));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    rd_val = reg_rdata;
  endtask
  function automatic logic pick(input int s, input int p);
    return s == 0 ? rx_frame_out[p] : (s == 1 ? tx_frame_out[p] : tx_path_frame[p]);
  endfunction
  task automatic rate(input int p, input logic [4:0] code, input logic [3:0] sel,
    input logic [4:0] sr, input logic [4:0] ar, input int f);
    logic b;
    int r;
    int c;
    longint e;
    wr(APG_CTRL_OFS[p], 16'h0000);
    wr(APG_RATE_OFS[p], {11'h000, code});
    wr(APG_SYSRATE_OFS, {11'h000, sr});
    wr(APG_ASYRATE_OFS, {11'h000, ar});
    wr(APG_CTRL_OFS[p], {8'h00, sel, 4'h1});
    b = 1'b1;
    r = -1;
    c = -1;
    while (r < 8)
    begin
      @(posedge clk);
      #1;
      if (bclk_out[p] === 1'b1 && b === 1'b0)
        r++;
      if (r >= 0)
        c++;
      b = bclk_out[p];
    end
    // the accumulator step is truncated, so eight periods run slightly long
    e = (longint'(8) << 25) / ((longint'(f) << 25) / APG_CLK_HZ);
    chk("bclk span", (c > e - 3 && c < e + 3) ? e : c, e);
    chk("async domain", async_domain[p], sel[3]);
  endtask
  task automatic fcount(input int s, input int n_exp);
    logic f;
    logic b;
    int r;
    int n;
    f = 1'b1;
    b = 1'b0;
    r = -1;
    n = 0;
    while (r < 1)
    begin
      @(posedge clk);
      #1;
      if (pick(s, 0) === 1'b1 && f === 1'b0)
        r++;
      if (r == 0 && bclk_out[0] === 1'b0 && b === 1'b1)
        n++;
      f = pick(s, 0);
      b = bclk_out[0];
    end
    chk("frame bits", n, n_exp);
  endtask
  task automatic reserved(input logic [4:0] code);
    logic b;
    int t;
    wr(APG_CTRL_OFS[0], 16'h0000);
    wr(APG_RATE_OFS[0], {11'h000, code});
    wr(APG_CTRL_OFS[0], 16'h0001);
    repeat (4) @(posedge clk);
    #1;
    b = bclk_out[0];
    t = 0;
    repeat (1000)
    begin
      @(posedge clk);
      #1;
      if (bclk_out[0] !== b)
        t++;
      b = bclk_out[0];
    end
    chk("reserved toggles", t, 0);
    rd(APG_STAT_OFS);
    chk("reserved flag", rd_val[6], 1'b1);
  endtask
  task automatic waitfr(input logic v);
    int k;
    k = 0;
    while (rx_frame_in[0] !== v && k < 500)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    repeat (4) @(posedge clk);
    #1;
    chk("slave tx path", tx_path_frame[0], v);
  endtask
  task automatic conflict(input int p, input logic [15:0] ctl, input logic [15:0] ofs,
    input logic [15:0] sl, input logic e);
    wr(APG_CTRL_OFS[p], ctl);
    wr(ofs, sl);
    repeat (4) @(posedge clk);
    #1;
    chk("config error", config_error[p], e);
    rd(APG_STAT_OFS);
    chk("status error", rd_val[p], e);
  endtask
  initial
  begin
    #400000;
    failures++;
    summarize();
  end
  initial
  begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    fe_en = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'b1;
    chk("oe after reset", {bclk_oe_n, rx_frame_oe_n, tx_frame_oe_n}, 9'h1ff);
    for (int p = 0; p < 3; p++)
    begin
      rd(APG_RATE_OFS[p]);
      chk("rate reset", rd_val, 16'h000c);
      rd(APG_RXDIV_OFS[p]);
      chk("rx div reset", rd_val, 16'h0040);
      rd(APG_TXDIV_OFS[p]);
      chk("tx div reset", rd_val, 16'h0040);
    end
    wr(APG_RXDIV_OFS[1], 16'hffff);
    rd(APG_RXDIV_OFS[1]);
    chk("rx div width", rd_val, 16'h1fff);
    rd(16'h0504);
    chk("unmapped read", rd_val, 16'h0000);
    rate(0, 5'h0c, 4'h0, 5'h00, 5'h08, APG_F48[10]);
    rate(0, 5'h11, 4'h0, 5'h08, 5'h00, APG_F44[15]);
    rate(0, 5'h11, 4'h8, 5'h08, 5'h10, APG_F48[15]);
    rate(1, 5'h11, 4'hf, 5'h00, 5'h0b, APG_F44[15]);
    rate(2, 5'h11, 4'h7, 5'h18, 5'h08, APG_F48[15]);
    rate(0, 5'h02, 4'h0, 5'h00, 5'h00, APG_F48[0]);
    reserved(5'h01);
    reserved(5'h12);
    wr(APG_CTRL_OFS[0], 16'h0000);
    wr(APG_RATE_OFS[0], 16'h0011);
    wr(APG_CTRL_OFS[0], 16'h0005);
    fcount(0, 64);
    wr(APG_RXDIV_OFS[0], 16'h0004);
    wr(APG_TXDIV_OFS[0], 16'h0006);
    fcount(0, 4);
    fcount(1, 6);
    fcount(2, 4);
    wr(APG_CTRL_OFS[0], 16'h0007);
    fcount(2, 6);
    wr(APG_CTRL_OFS[0], 16'h0000);
    fe_en = 1'b1;
    waitfr(1'b0);
    waitfr(1'b1);
    // tx source set while slave: tx path follows the tx frame pin
    wr(APG_CTRL_OFS[0], 16'h0002);
    waitfr(1'b0);
    chk("slave oe", bclk_oe_n[0], 1'b1);
    fe_en = 1'b0;
    for (int p = 0; p < 3; p++)
    begin
      conflict(p, 16'h0300, APG_RXSL_OFS[p], 16'h0000, 1'b1);
      conflict(p, 16'h0300, APG_RXSL_OFS[p], 16'h0100, 1'b0);
      conflict(p, 16'h0c00, APG_TXSL_OFS[p], 16'h0707, 1'b1);
      conflict(p, 16'h0400, APG_TXSL_OFS[p], 16'h0707, 1'b0);
    end
    summarize();
  end
endmodule
